/* dv/can_bus_node.sv */
// other node on the shared bus: bit timing and dominant bursts
`timescale 1ns/1ps
`default_nettype none
module can_bus_node #(
    parameter int BIT_CYC = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // device pin
    input wire logic tx_pin,
    input wire logic tx_oe,
    // stimulus
    input wire logic dom_req,
    // bus view
    output logic bit_tick,
    output logic bus_level
);
    int cnt_q;
    logic tick_q;
    // wired-and with pull-up: a released pin reads recessive
    assign bus_level = !dom_req && (!tx_oe || tx_pin);
    assign bit_tick = tick_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == BIT_CYC - 1) ? 0 : cnt_q + 1;
            tick_q <= (cnt_q == BIT_CYC - 1);
        end
    end
endmodule
`default_nettype wire

/* dv/can_mode_assertions.sv */
// concurrent checks of the mode controller ports
`timescale 1ns/1ps
`default_nettype none
module can_mode_assertions
    import can_mode_pkg::*;
#(
    parameter can_mode_pkg::mode_code_t MODE_INIT = can_mode_pkg::DEF_MODE_INIT,
    parameter can_mode_pkg::mode_code_t MODE_LISTEN_ONLY = can_mode_pkg::DEF_MODE_LISTEN_ONLY,
    parameter can_mode_pkg::mode_code_t MODE_LOOPBACK = can_mode_pkg::DEF_MODE_LOOPBACK
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // watched ports
    input wire logic [15:0] ctrl1_rdata,
    input wire logic cfg_wr_req,
    input wire logic cfg_wr_allow,
    input wire logic core_tx,
    input wire logic core_rx,
    input wire logic tx_enable,
    input wire logic rx_enable,
    input wire logic tx_start,
    input wire logic err_cnt_clear,
    input wire logic err_cnt_hold,
    input wire logic ignore_errors,
    input wire logic accept_all,
    input wire logic tx_send_request,
    input wire logic tx_aborted_flag,
    input wire logic wake_interrupt_flag,
    input wire logic can_transmit_pin,
    input wire logic pins_to_port_io
);
    import can_mode_pkg::*;
    mode_code_t mode_status_field;
    mode_code_t mode_request_field;
    assign mode_status_field = ctrl1_rdata[CTRL1_STAT_HI:CTRL1_STAT_LO];
    assign mode_request_field = ctrl1_rdata[CTRL1_REQ_HI:CTRL1_REQ_LO];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_mode_swap;
        $changed(mode_status_field);
    endsequence
    sequence s_abort_seen;
        $rose(tx_aborted_flag);
    endsequence
    a_status_echo: assert property (s_mode_swap |-> mode_status_field == mode_request_field)
        else $error("status differs from request");
    a_cfg_lock: assert property (cfg_wr_allow == (cfg_wr_req && mode_status_field == MODE_INIT))
        else $error("config write gate wrong");
    a_init_quiet: assert property (mode_status_field == MODE_INIT
        |-> !tx_enable && !rx_enable && err_cnt_clear)
        else $error("init mode not quiet");
    a_disable_pins: assert property (mode_status_field == MODE_DISABLE
        |-> pins_to_port_io && !tx_enable && !rx_enable && !err_cnt_clear)
        else $error("disable mode pins or counters wrong");
    a_normal_pins: assert property (mode_status_field == MODE_NORMAL
        |-> !pins_to_port_io && tx_enable && rx_enable)
        else $error("normal mode not on the bus");
    a_listen_passive: assert property (mode_status_field == MODE_LISTEN_ONLY
        |-> !tx_enable && rx_enable && err_cnt_hold && can_transmit_pin)
        else $error("listen-only not passive");
    a_listen_all: assert property (mode_status_field == MODE_LISTEN_ALL
        |-> ignore_errors && accept_all)
        else $error("listen-all not accepting");
    a_loop_route: assert property (mode_status_field == MODE_LOOPBACK
        |-> core_rx == core_tx && pins_to_port_io)
        else $error("loopback route wrong");
    a_tx_gated: assert property (!tx_enable |-> !tx_start)
        else $error("start while transmit gated");
    a_abort_clear: assert property (s_abort_seen |-> !tx_send_request)
        else $error("abort left send request");
    a_wake_source: assert property ($rose(wake_interrupt_flag)
        |-> $past(mode_status_field) == MODE_DISABLE)
        else $error("wake flag outside disable");
endmodule
bind can_operating_mode_control can_mode_assertions #(.MODE_INIT(MODE_INIT),
    .MODE_LISTEN_ONLY(MODE_LISTEN_ONLY), .MODE_LOOPBACK(MODE_LOOPBACK)) u_chk (.clk_sys,
    .rst_n, .ctrl1_rdata, .cfg_wr_req, .cfg_wr_allow, .core_tx, .core_rx, .tx_enable,
    .rx_enable, .tx_start, .err_cnt_clear, .err_cnt_hold, .ignore_errors, .accept_all,
    .tx_send_request, .tx_aborted_flag, .wake_interrupt_flag, .can_transmit_pin,
    .pins_to_port_io);
`default_nettype wire

/* dv/test_can_operating_mode_control.sv */
// directed bench of the mode controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); miscompares++; end end
module test_can_operating_mode_control;
    import can_mode_pkg::*;
    logic clk_sys;
    logic rst_n = 0, ctrl1_wr = 0, cfg2_wr = 0, cfg_wr_req = 0, sleep = 0, core_tx = 1;
    logic tx_busy = 0, error_event = 0, error_flag_req = 0, ack_req = 0, dom_req = 0;
    logic tx_send_request_set = 0, wake_flag_clear = 0;
    logic [15:0] ctrl1_wdata = 16'h0000, cfg2_wdata = 16'h0000, ctrl1_rdata, cfg2_rdata;
    logic [31:0] assembly_word = 32'h0000_0000, rxbuf_rd_data;
    logic [1:0] assembly_index = 2'h0, rxbuf_rd_addr = 2'h0;
    logic cfg_wr_allow, bit_tick, core_rx, tx_enable, rx_enable, tx_start, err_cnt_clear;
    logic err_cnt_hold, ignore_errors, accept_all, tx_send_request, tx_aborted_flag;
    logic wake_interrupt_flag, can_receive_pin, can_transmit_pin, can_transmit_pin_oe;
    logic pins_to_port_io;
    mode_code_t stat;
    int miscompares = 0, tests_run = 0, t, i;
    assign stat = ctrl1_rdata[CTRL1_STAT_HI:CTRL1_STAT_LO];
    can_operating_mode_control dut (.clk_sys, .rst_n, .ctrl1_wr, .ctrl1_wdata, .ctrl1_rdata,
        .cfg2_wr, .cfg2_wdata, .cfg2_rdata, .cfg_wr_req, .cfg_wr_allow, .bit_tick, .sleep,
        .core_tx, .core_rx, .tx_busy, .error_event, .error_flag_req, .ack_req, .tx_enable,
        .rx_enable, .tx_start, .err_cnt_clear, .err_cnt_hold, .ignore_errors, .accept_all,
        .tx_send_request_set, .tx_send_request, .tx_aborted_flag, .wake_flag_clear,
        .wake_interrupt_flag, .assembly_word, .assembly_index, .rxbuf_rd_addr,
        .rxbuf_rd_data, .can_receive_pin, .can_transmit_pin, .can_transmit_pin_oe,
        .pins_to_port_io);
    can_bus_node node (.clk_sys, .rst_n, .tx_pin(can_transmit_pin),
        .tx_oe(can_transmit_pin_oe), .dom_req, .bit_tick, .bus_level(can_receive_pin));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic results;
        $display("counts: %0d run, %0d failed", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic req(input mode_code_t m);
        @(posedge clk_sys);
        ctrl1_wr <= 1'b1;
        ctrl1_wdata <= {5'h00, m, 8'h00};
        @(posedge clk_sys);
        ctrl1_wr <= 1'b0;
    endtask
    // idle ticks counted from the request; one tick may fall before counting starts
    task automatic wait_mode(input mode_code_t m, input int min_ticks);
        t = 0;
        for (i = 0; i < 3000 && stat !== m; i++) begin
            @(posedge clk_sys);
            if (bit_tick === 1'b1) t++;
        end
        `CHK("mode status", m, stat)
        `CHK("idle ticks", 1'b1, t >= min_ticks)
    endtask
    task automatic go(input mode_code_t m, input int min_ticks);
        req(m);
        wait_mode(m, min_ticks);
    endtask
    task automatic pulse_send;
        @(posedge clk_sys);
        tx_send_request_set <= 1'b1;
        @(posedge clk_sys);
        tx_send_request_set <= 1'b0;
    endtask
    initial begin
        #(20 * 60000);
        miscompares++;
        results();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        `CHK("reset mode", DEF_MODE_INIT, stat)
        cfg_wr_req <= 1'b1;
        cfg2_wr <= 1'b1;
        cfg2_wdata <= 16'h4000;
        @(posedge clk_sys);
        cfg2_wr <= 1'b0;
        #1 `CHK("allow in init", 1'b1, cfg_wr_allow)
        `CHK("filter enable", 1'b1, cfg2_rdata[CFG2_WAKE_FILTER_BIT])
        $display("test init config done");
        go(MODE_NORMAL, 0);
        pulse_send();
        t = 0;
        for (i = 0; i < 3000 && tx_start !== 1'b1; i++) begin
            @(posedge clk_sys);
            if (bit_tick === 1'b1) t++;
        end
        `CHK("start after idle", 1'b1, t >= IDLE_BITS - 1)
        @(posedge clk_sys);
        cfg2_wr <= 1'b1;
        cfg2_wdata <= 16'h0000;
        @(posedge clk_sys);
        cfg2_wr <= 1'b0;
        #1 `CHK("allow on-line", 1'b0, cfg_wr_allow)
        `CHK("filter kept", 1'b1, cfg2_rdata[CFG2_WAKE_FILTER_BIT])
        @(posedge clk_sys);
        core_tx <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 `CHK("tx pin dominant", 1'b0, can_transmit_pin)
        `CHK("tx pin owned", 1'b1, can_transmit_pin_oe)
        @(posedge clk_sys);
        core_tx <= 1'b1;
        $display("test normal done");
        go(DEF_MODE_INIT, IDLE_BITS - 1);
        go(MODE_NORMAL, 0);
        pulse_send();
        req(MODE_DISABLE);
        repeat (3) @(posedge clk_sys);
        #1 `CHK("aborted flag", 1'b1, tx_aborted_flag)
        `CHK("send request", 1'b0, tx_send_request)
        wait_mode(MODE_DISABLE, IDLE_BITS - 1);
        dom_req <= 1'b1;
        repeat (16) @(posedge clk_sys);
        dom_req <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 `CHK("wake flag", 1'b1, wake_interrupt_flag)
        @(posedge clk_sys);
        wake_flag_clear <= 1'b1;
        @(posedge clk_sys);
        wake_flag_clear <= 1'b0;
        #1 `CHK("wake cleared", 1'b0, wake_interrupt_flag)
        @(posedge clk_sys);
        sleep <= 1'b1;
        dom_req <= 1'b1;
        repeat (2) @(posedge clk_sys);
        dom_req <= 1'b0;
        repeat (8) @(posedge clk_sys);
        #1 `CHK("wake glitch", 1'b0, wake_interrupt_flag)
        @(posedge clk_sys);
        sleep <= 1'b0;
        $display("test abort and disable done");
        go(DEF_MODE_INIT, 0);
        error_flag_req <= 1'b1;
        ack_req <= 1'b1;
        go(DEF_MODE_LISTEN_ONLY, 0);
        core_tx <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 `CHK("listen tx pin", 1'b1, can_transmit_pin)
        `CHK("listen tx oe", 1'b0, can_transmit_pin_oe)
        @(posedge clk_sys);
        core_tx <= 1'b1;
        go(DEF_MODE_INIT, IDLE_BITS - 1);
        error_flag_req <= 1'b0;
        ack_req <= 1'b0;
        go(DEF_MODE_LOOPBACK, 0);
        core_tx <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 `CHK("loop rx", 1'b0, core_rx)
        @(posedge clk_sys);
        core_tx <= 1'b1;
        go(DEF_MODE_INIT, IDLE_BITS - 1);
        $display("test passive modes done");
        go(MODE_LISTEN_ALL, 0);
        @(posedge clk_sys);
        assembly_word <= 32'h5a5a_c3c3;
        assembly_index <= 2'h2;
        rxbuf_rd_addr <= 2'h2;
        error_event <= 1'b1;
        @(posedge clk_sys);
        error_event <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 `CHK("copied word", 32'h5a5a_c3c3, rxbuf_rd_data)
        @(posedge clk_sys);
        tx_busy <= 1'b1;
        req(DEF_MODE_INIT);
        repeat (300) @(posedge clk_sys);
        `CHK("init held", MODE_LISTEN_ALL, stat)
        tx_busy <= 1'b0;
        wait_mode(DEF_MODE_INIT, 0);
        $display("test listen-all done");
        results();
    end
endmodule
`default_nettype wire

/* logic/bus_idle_detect.sv */
// counts consecutive recessive bits to find bus idle
`timescale 1ns/1ps
`default_nettype none
module bus_idle_detect #(
    parameter int IDLE_LEN = 11
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // bit stream
    input wire logic bit_tick,
    input wire logic rx_bit,
    input wire logic restart,
    // result
    output logic idle
);
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    localparam logic [4:0] LIMIT = 5'(IDLE_LEN);
    assign idle = (cnt_q >= LIMIT);
    always_comb begin
        cnt_d = cnt_q;
        if (restart) begin
            cnt_d = 5'h00;
        end else if (bit_tick) begin
            if (!rx_bit) begin
                cnt_d = 5'h00;
            end else if (!idle) begin
                cnt_d = cnt_q + 5'h01;
            end
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

/* logic/can_operating_mode_control.sv */
// operating-mode controller of the can module
`timescale 1ns/1ps
`default_nettype none
module can_operating_mode_control
    import can_mode_pkg::*;
#(
    parameter can_mode_pkg::mode_code_t MODE_INIT = can_mode_pkg::DEF_MODE_INIT,
    parameter can_mode_pkg::mode_code_t MODE_LISTEN_ONLY = can_mode_pkg::DEF_MODE_LISTEN_ONLY,
    parameter can_mode_pkg::mode_code_t MODE_LOOPBACK = can_mode_pkg::DEF_MODE_LOOPBACK,
    parameter int IDLE_LEN = can_mode_pkg::IDLE_BITS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // control register 1 write port
    input wire logic ctrl1_wr,
    input wire logic [15:0] ctrl1_wdata,
    output logic [15:0] ctrl1_rdata,
    // config register 2 write port
    input wire logic cfg2_wr,
    input wire logic [15:0] cfg2_wdata,
    output logic [15:0] cfg2_rdata,
    // other protected registers: write strobe in, permitted strobe out
    input wire logic cfg_wr_req,
    output logic cfg_wr_allow,
    // bit timing and sleep
    input wire logic bit_tick,
    input wire logic sleep,
    // protocol engine side
    input wire logic core_tx,
    output logic core_rx,
    input wire logic tx_busy,
    input wire logic error_event,
    input wire logic error_flag_req,
    input wire logic ack_req,
    output logic tx_enable,
    output logic rx_enable,
    output logic tx_start,
    output logic err_cnt_clear,
    output logic err_cnt_hold,
    output logic ignore_errors,
    output logic accept_all,
    // send request of the pending buffer
    input wire logic tx_send_request_set,
    output logic tx_send_request,
    output logic tx_aborted_flag,
    // wake
    input wire logic wake_flag_clear,
    output logic wake_interrupt_flag,
    // message assembly buffer copy
    input wire logic [MSG_W-1:0] assembly_word,
    input wire logic [BUF_AW-1:0] assembly_index,
    input wire logic [BUF_AW-1:0] rxbuf_rd_addr,
    output logic [MSG_W-1:0] rxbuf_rd_data,
    // pins
    input wire logic can_receive_pin,
    output logic can_transmit_pin,
    output logic can_transmit_pin_oe,
    output logic pins_to_port_io
);
    import can_mode_pkg::*;

    // modes in which the block may transmit; in loopback the transmission stays internal and never reaches the bus
    function automatic logic tx_allowed(input mode_code_t m);
        return (m == MODE_NORMAL) || (m == MODE_LOOPBACK) || (m == MODE_LISTEN_ALL);
    endfunction

    // receive pin synchroniser
    logic rx_meta_q;
    logic rx_sync_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
        end else begin
            rx_meta_q <= can_receive_pin;
            rx_sync_q <= rx_meta_q;
        end
    end

    // wake low-pass: a dominant level must persist to count
    // short glitches on a sleeping bus then never raise a wake
    logic [FILTER_LEN-1:0] filt_q;
    logic filt_rx_q;
    logic wake_filter_enable_q;
    logic filt_active;
    logic rx_filtered;
    assign filt_active = wake_filter_enable_q && sleep;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            filt_q <= '1;
            filt_rx_q <= 1'b1;
        end else begin
            filt_q <= {filt_q[FILTER_LEN-2:0], rx_sync_q};
            if (filt_q == '0) begin
                filt_rx_q <= 1'b0;
            end else if (filt_q == '1) begin
                filt_rx_q <= 1'b1;
            end
        end
    end
    assign rx_filtered = filt_active ? filt_rx_q : rx_sync_q;

    // registers
    logic [2:0] req_q;
    mode_code_t mode_q;
    mode_state_t st_q;
    mode_state_t st_d;
    logic [15:0] ctrl1_other_q;
    logic [15:0] cfg2_q;
    logic in_init;
    logic bus_idle;
    logic idle_restart;
    logic bus_rx;

    assign in_init = (mode_q == MODE_INIT);
    // protected registers outside this block are only writable in init
    assign cfg_wr_allow = cfg_wr_req && in_init;

    // request field stays writable so software can leave init
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            req_q <= MODE_INIT;
        end else if (ctrl1_wr) begin
            req_q <= ctrl1_wdata[CTRL1_REQ_HI:CTRL1_REQ_LO];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl1_other_q <= 16'h0000;
        end else if (ctrl1_wr && in_init) begin
            ctrl1_other_q <= ctrl1_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg2_q <= 16'h0000;
        end else if (cfg2_wr && in_init) begin
            cfg2_q <= cfg2_wdata;
        end
    end
    assign wake_filter_enable_q = cfg2_q[CFG2_WAKE_FILTER_BIT];
    assign cfg2_rdata = cfg2_q;

    always_comb begin
        ctrl1_rdata = ctrl1_other_q;
        ctrl1_rdata[CTRL1_REQ_HI:CTRL1_REQ_LO] = req_q;
        ctrl1_rdata[CTRL1_STAT_HI:CTRL1_STAT_LO] = mode_q;
    end

    // loopback and pin routing
    logic is_loop;
    logic is_listen_only;
    logic is_listen_all;
    logic is_normal;
    logic is_disable;
    logic can_owns_tx;
    assign is_loop = (mode_q == MODE_LOOPBACK);
    assign is_listen_only = (mode_q == MODE_LISTEN_ONLY);
    assign is_listen_all = (mode_q == MODE_LISTEN_ALL);
    assign is_normal = (mode_q == MODE_NORMAL);
    assign is_disable = (mode_q == MODE_DISABLE);
    assign bus_rx = is_loop ? core_tx : rx_filtered;
    assign core_rx = bus_rx;
    // init keeps the pin but never drives it dominant
    assign can_owns_tx = is_normal || is_listen_all || in_init;
    assign pins_to_port_io = is_disable || is_loop;
    assign can_transmit_pin_oe = can_owns_tx && !is_listen_only;

    bus_idle_detect #(
        .IDLE_LEN(IDLE_LEN)
    ) u_idle (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .bit_tick(bit_tick),
        .rx_bit(bus_rx),
        .restart(idle_restart),
        .idle(bus_idle)
    );

    // mode change sequencer
    logic pend;
    assign pend = (req_q != mode_q);
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_RUN: begin
                if (pend) begin
                    st_d = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                // no change while a frame is on the wire
                if (!pend) begin
                    st_d = ST_RUN;
                end else if (!tx_busy) begin
                    st_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!pend) begin
                    st_d = ST_RUN;
                end else if (tx_busy) begin
                    st_d = ST_DRAIN;
                // init and disable are off the bus and need no idle wait
                end else if (bus_idle || in_init || is_disable) begin
                    st_d = ST_SWAP;
                end
            end
            ST_SWAP: begin
                st_d = ST_RUN;
            end
            default: begin
                st_d = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_RUN;
        end else begin
            st_q <= st_d;
        end
    end

    // status follows the request only in the swap cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= MODE_INIT;
        end else if (st_q == ST_SWAP && pend) begin
            mode_q <= req_q;
        end
    end

    // transmit gating after mode entry
    logic entered;
    logic tx_wait_q;
    logic req_start;
    assign entered = (st_q == ST_SWAP) && pend;
    // a new request must see its own idle time, not idle left from before
    assign req_start = (st_q == ST_RUN) && pend;
    assign idle_restart = entered || req_start;
    // set on entry into a transmitting mode, cleared by the first idle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_wait_q <= 1'b0;
        end else if (entered) begin
            tx_wait_q <= tx_allowed(req_q);
        end else if (bus_idle) begin
            tx_wait_q <= 1'b0;
        end
    end

    logic abort_now;
    assign abort_now = tx_wait_q && tx_send_request && (req_q == MODE_DISABLE);
    // abort outranks a new send request in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_send_request <= 1'b0;
        end else if (abort_now) begin
            tx_send_request <= 1'b0;
        end else if (tx_send_request_set) begin
            tx_send_request <= 1'b1;
        end else if (tx_start) begin
            tx_send_request <= 1'b0;
        end
    end

    // a fresh send request clears an old abort
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_aborted_flag <= 1'b0;
        end else if (abort_now) begin
            tx_aborted_flag <= 1'b1;
        end else if (tx_send_request_set) begin
            tx_aborted_flag <= 1'b0;
        end
    end

    assign tx_enable = tx_allowed(mode_q) && !is_disable;
    assign rx_enable = !in_init && !is_disable;
    // start needs the post-entry idle wait done and a quiet bus
    assign tx_start = tx_enable && tx_send_request && !tx_wait_q
                      && bus_idle && !tx_busy;
    assign err_cnt_clear = in_init;
    assign err_cnt_hold = is_disable || is_listen_only;
    assign ignore_errors = is_listen_all;
    assign accept_all = is_listen_all;

    // transmit pin: listen-only sends no error flags or acks
    logic drive_dom;
    assign drive_dom = tx_enable && !core_tx && !is_loop
                       && !(is_listen_only && (error_flag_req || ack_req));
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            can_transmit_pin <= 1'b1;
        end else begin
            can_transmit_pin <= !drive_dom;
        end
    end

    // wake on dominant edge while disabled; set wins over clear
    logic prev_rx_q;
    logic wake_evt;
    // resets to the idle level so release of reset is no false edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev_rx_q <= 1'b1;
        end else begin
            prev_rx_q <= rx_filtered;
        end
    end
    assign wake_evt = is_disable && prev_rx_q && !rx_filtered;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wake_interrupt_flag <= 1'b0;
        end else if (wake_evt) begin
            wake_interrupt_flag <= 1'b1;
        end else if (wake_flag_clear) begin
            wake_interrupt_flag <= 1'b0;
        end
    end

    // copy assembled words on error in listen-all
    logic copy_en;
    assign copy_en = is_listen_all && error_event;
    rx_copy_buffer #(
        .W(MSG_W),
        .AW(BUF_AW)
    ) u_rxbuf (
        .clk_sys(clk_sys),
        .wr_en(copy_en),
        .wr_addr(assembly_index),
        .wr_data(assembly_word),
        .rd_addr(rxbuf_rd_addr),
        .rd_data(rxbuf_rd_data)
    );
endmodule
`default_nettype wire

/* logic/rx_copy_buffer.sv */
// small receive buffer, registered read
`timescale 1ns/1ps
`default_nettype none
module rx_copy_buffer #(
    parameter int W = 32,
    parameter int AW = 2
) (
    // clock
    input wire logic clk_sys,
    // write side
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    // read side
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data
);
    logic [W-1:0] mem [0:(1<<AW)-1];
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

/* shared/can_mode_pkg.sv */
// constants and types for the can operating-mode controller
// Operation
// - software mode request is taken from control register 1 bits 10 to 8.
// - granted mode is reported in control register 1 bits 7 to 5.
// - mode and status change only on bus idle, 11 recessive bits, except when leaving init or disable (no idle wait).
// - initialization mode: no tx or rx, error counters cleared, flags kept.
// - configuration register writes allowed only in initialization mode.
// - initialization entry waits until any frame transmission finishes.
// - disable mode: no tx or rx, wake flag on activity, counters kept.
// - request 001 waits 11 recessive bits (none when coming from init) then shows 001 in status.
// - disable mode returns transmit and receive pins to port io.
// - optional receive low-pass filter in sleep, enabled by config 2 bit 14.
// - transmission right after mode entry waits 11 recessive bits first.
// - disable during that wait aborts: aborted flag set, send request cleared.
// - request 000 is normal mode: pins owned by can, tx and rx active.
// - listen-only is passive: transmit pin released (oe low, not routed to port io), receive stays input.
// - listen-only sends no error flags or acks, error counters inactive.
// - request 111 is listen-all: errors ignored, every message accepted.
// - listen-all copies assembly buffer into receive buffer on error.
// - loopback ties internal tx to internal rx, both pins to port io.
package can_mode_pkg;
    typedef logic [2:0] mode_code_t;
    localparam mode_code_t MODE_NORMAL = 3'h0;
    localparam mode_code_t MODE_DISABLE = 3'h1;
    localparam mode_code_t MODE_LISTEN_ALL = 3'h7;
    localparam mode_code_t DEF_MODE_LOOPBACK = 3'h2;
    localparam mode_code_t DEF_MODE_LISTEN_ONLY = 3'h3;
    localparam mode_code_t DEF_MODE_INIT = 3'h4;
    localparam int CTRL1_REQ_HI = 10;
    localparam int CTRL1_REQ_LO = 8;
    localparam int CTRL1_STAT_HI = 7;
    localparam int CTRL1_STAT_LO = 5;
    localparam int CFG2_WAKE_FILTER_BIT = 14;
    localparam int IDLE_BITS = 11;
    localparam int FILTER_LEN = 4;
    localparam int ERR_CNT_W = 8;
    localparam int MSG_W = 32;
    localparam int BUF_AW = 2;
    typedef enum logic [3:0] {
        ST_RUN  = 4'b0001,
        ST_WAIT = 4'b0010,
        ST_DRAIN = 4'b0100,
        ST_SWAP = 4'b1000
    } mode_state_t;
endpackage
